// File: core/psc_pkg.sv
/*
 * parameter store control package: register indices, defaults, status codes, timing.
 * assumes a 20 MHz system clock and a 32-bit apb register bus.
 */
package psc_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_AVG_INTERVAL = 8'h5A;
	localparam logic [7:0] IDX_VOLT_THR = 8'h68;
	localparam logic [7:0] IDX_TEMP_THR = 8'h69;
	localparam logic [7:0] IDX_RSVD_A_LO = 8'h6A;
	localparam logic [7:0] IDX_RSVD_A_HI = 8'h73;
	localparam logic [7:0] IDX_CMD = 8'h74;
	localparam logic [7:0] IDX_RESTART = 8'h75;
	localparam logic [7:0] IDX_RSVD_B_LO = 8'h76;
	localparam logic [7:0] IDX_RSVD_B_HI = 8'h7F;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h81;
	// reset and factory values
	localparam logic [15:0] DEF_VOLT_THR = 16'h00B9;
	localparam logic [15:0] DEF_TEMP_THR = 16'h0046;
	localparam logic [15:0] DEF_AVG_INTERVAL = 16'h0064;
	localparam logic [7:0] DEF_BUS_ADDR = 8'h01;
	localparam logic [15:0] DEF_BAUD = 16'h4B00;
	// command codes, 16-bit signed
	localparam logic [15:0] CMD_FULL_REF = 16'hFFFE;
	localparam logic [15:0] CMD_KEEP_REF = 16'hFFFF;
	localparam logic [15:0] CMD_NONE = 16'h0000;
	localparam logic [15:0] CMD_SAVE = 16'h0001;
	localparam logic [15:0] CMD_FULL_STILL = 16'h0002;
	localparam logic [15:0] CMD_KEEP_STILL = 16'h0003;
	localparam logic [15:0] CMD_RESTART = 16'h0001;
	// status codes of the command register
	localparam logic [15:0] BUSY_MASK = 16'hFC00;
	localparam logic [15:0] ERR_MASK = 16'h03FF;
	localparam logic [15:0] CODE_OK = 16'h0000;
	localparam logic [15:0] CODE_BUSY = 16'h8000;
	localparam logic [15:0] CODE_NVM_ERR = 16'h0001;
	localparam logic [15:0] CODE_TIMEOUT = 16'h0002;
	localparam logic [15:0] CODE_CORRUPT = 16'h0100;
	// interrupt bits
	localparam int IRQ_SAVE_OK = 0;
	localparam int IRQ_SAVE_ERR = 1;
	localparam int IRQ_RESTORE = 2;
	localparam int IRQ_POWER = 3;
	localparam logic [3:0] IRQ_ZERO = 4'h0;
	// timing
	localparam int unsigned AVG_STEP_MS = 5;
	localparam int unsigned AVG_STEP_CYC = AVG_STEP_MS * (CLK_HZ / 1000);
	localparam int unsigned SAVE_MAX_MS = 2000;
	localparam int unsigned SAVE_MAX_CYC = SAVE_MAX_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		SAVE_IDLE = 2'b00,
		SAVE_REQ = 2'b01,
		SAVE_WAIT = 2'b10
	} psc_save_state_e;

	typedef struct packed {
		logic busy;
		logic done_ok;
		logic done_err;
		logic [15:0] code;
	} psc_save_s;
endpackage : psc_pkg

// File: core/psc_save_engine.sv
/*
 * save sequencer: drives the non-volatile store and keeps the command status code.
 * assumes the store handshake runs on clk_i and boot_mem_ok_i is a stable strap.
 */
`timescale 1ns/1ns
`default_nettype none
module psc_save_engine
	import psc_pkg::*;
#(
	parameter int unsigned SAVE_CYC = SAVE_MAX_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic boot_mem_ok_i,
	input wire logic nvm_done_i,
	input wire logic nvm_err_i,
	output logic nvm_req_o,
	output psc_save_s stat_o
);
	psc_save_state_e state;
	logic [31:0] tmo;
	logic boot_seen;

	// strap caught at the first edge after release, never under reset
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_seen <= 1'b0;
		end else begin
			boot_seen <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= SAVE_IDLE;
			tmo <= 32'h0000_0000;
			stat_o <= '0;
		end else begin
			stat_o.done_ok <= 1'b0;
			stat_o.done_err <= 1'b0;
			if (!boot_seen) begin
				stat_o.code <= boot_mem_ok_i ? CODE_OK : CODE_CORRUPT;
			end
			case (state)
				SAVE_IDLE: begin
					if (start_i && boot_seen) begin
						state <= SAVE_REQ;
						tmo <= 32'h0000_0000;
						stat_o.busy <= 1'b1;
						stat_o.code <= CODE_BUSY;
					end
				end
				SAVE_REQ, SAVE_WAIT: begin
					state <= SAVE_WAIT;
					tmo <= tmo + 32'h0000_0001;
					if (nvm_done_i) begin
						state <= SAVE_IDLE;
						stat_o.busy <= 1'b0;
						stat_o.code <= nvm_err_i ? CODE_NVM_ERR : CODE_OK;
						stat_o.done_ok <= !nvm_err_i;
						stat_o.done_err <= nvm_err_i;
					end else if (tmo >= SAVE_CYC - 1) begin
						// a store that never answers ends as an error, not a hang
						state <= SAVE_IDLE;
						stat_o.busy <= 1'b0;
						stat_o.code <= CODE_TIMEOUT;
						stat_o.done_err <= 1'b1;
					end
				end
				default: begin
					state <= SAVE_IDLE;
				end
			endcase
		end
	end

	assign nvm_req_o = (state != SAVE_IDLE);

	property p_busy_code;
		@(posedge clk_i) disable iff (sys_rst_i) (state == SAVE_WAIT) |-> ((stat_o.code & BUSY_MASK) != 16'h0000);
	endproperty
	a_busy_code: assert property (p_busy_code) else $error("save running without busy code");

	property p_err_code;
		@(posedge clk_i) disable iff (sys_rst_i)
			stat_o.done_err |-> ((stat_o.code & BUSY_MASK) == 16'h0000) && ((stat_o.code & ERR_MASK) != 16'h0000);
	endproperty
	a_err_code: assert property (p_err_code) else $error("failed save not reported");

	property p_boot_code;
		@(posedge clk_i) disable iff (sys_rst_i)
			$rose(boot_seen) |-> (stat_o.code == ($past(boot_mem_ok_i) ? CODE_OK : CODE_CORRUPT));
	endproperty
	a_boot_code: assert property (p_boot_code) else $error("boot integrity code wrong");
endmodule : psc_save_engine
`default_nettype wire

// File: core/psc_supply_avg.sv
/*
 * motor supply averaging and threshold compare.
 * assumes supply_meas_i is a sample produced on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module psc_supply_avg
	import psc_pkg::*;
#(
	parameter int unsigned STEP_CYC = AVG_STEP_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] supply_meas_i,
	input wire logic [15:0] interval_i,
	input wire logic [15:0] thr_i,
	output logic present_o
);
	logic [31:0] pre;
	logic [15:0] cnt;
	logic [31:0] sum;
	logic [15:0] span;
	logic step;

	// a zero interval behaves as one step so the flag still updates
	assign span = (interval_i == 16'h0000) ? 16'h0001 : interval_i;
	assign step = (pre >= STEP_CYC - 1);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre <= 32'h0000_0000;
		end else begin
			pre <= step ? 32'h0000_0000 : pre + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= 16'h0000;
			sum <= 32'h0000_0000;
			present_o <= 1'b0;
		end else if (step) begin
			if (cnt + 16'h0001 >= span) begin
				// sum/n >= thr without a divider
				present_o <= (sum + {16'h0000, supply_meas_i}) >= (thr_i * span);
				cnt <= 16'h0000;
				sum <= 32'h0000_0000;
			end else begin
				cnt <= cnt + 16'h0001;
				sum <= sum + {16'h0000, supply_meas_i};
			end
		end
	end

	property p_present_on_step;
		@(posedge clk_i) disable iff (sys_rst_i) $changed(present_o) |-> $past(step);
	endproperty
	a_present_on_step: assert property (p_present_on_step) else $error("flag moved off an interval end");
endmodule : psc_supply_avg
`default_nettype wire

// File: core/psc_regs.sv
/*
 * parameter store control register bank on apb.
 * assumes a single clk_i domain; device restart is carried out by the system reset logic.
 */
`timescale 1ns/1ns
`default_nettype none
module psc_regs
	import psc_pkg::*;
#(
	parameter int unsigned STEP_CYC = AVG_STEP_CYC,
	parameter int unsigned SAVE_CYC = SAVE_MAX_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] supply_meas_i,
	input wire logic boot_mem_ok_i,
	input wire logic nvm_done_i,
	input wire logic nvm_err_i,
	output logic nvm_req_o,
	output logic motor_power_o,
	output logic [15:0] temp_thr_o,
	output logic [7:0] bus_addr_o,
	output logic [15:0] baud_o,
	output logic ref_run_o,
	output logic dev_restart_o,
	output logic irq_o
);
	logic [15:0] volt_thr;
	logic [15:0] temp_thr;
	logic [15:0] avg_interval;
	logic [7:0] pend_addr;
	logic [15:0] pend_baud;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic link_loaded;
	logic power_q;
	psc_save_s save_st;
	logic [7:0] idx;
	logic access;
	logic wr_en;
	logic rd_done;
	logic mapped;
	logic rsvd;
	logic [15:0] wval;
	logic [15:0] next_rdata;
	logic cmd_wr;
	logic restore_any;
	logic restore_full;
	logic save_go;
	logic [3:0] irq_set;

	assign idx = paddr[9:2];
	assign access = psel && penable;
	// one wait state: data is registered at the same edge that raises pready
	assign wr_en = access && pready && pwrite;
	assign rd_done = access && pready && !pwrite;
	assign wval = pwdata[15:0];
	assign rsvd = ((idx >= IDX_RSVD_A_LO) && (idx <= IDX_RSVD_A_HI))
		|| ((idx >= IDX_RSVD_B_LO) && (idx <= IDX_RSVD_B_HI));
	assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
		&& (rsvd || idx == IDX_AVG_INTERVAL || idx == IDX_VOLT_THR || idx == IDX_TEMP_THR
		|| idx == IDX_CMD || idx == IDX_RESTART || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
	assign cmd_wr = wr_en && mapped && (idx == IDX_CMD) && !save_st.busy;
	assign restore_full = cmd_wr && ((wval == CMD_FULL_REF) || (wval == CMD_FULL_STILL));
	assign restore_any = restore_full || (cmd_wr && ((wval == CMD_KEEP_REF) || (wval == CMD_KEEP_STILL)));
	assign save_go = cmd_wr && (wval == CMD_SAVE);

	always_comb begin
		next_rdata = 16'h0000;
		case (idx)
			IDX_AVG_INTERVAL: next_rdata = avg_interval;
			IDX_VOLT_THR: next_rdata = volt_thr;
			IDX_TEMP_THR: next_rdata = temp_thr;
			IDX_CMD: next_rdata = save_st.code;
			IDX_RESTART: next_rdata = 16'h0000;
			IDX_IRQ_STATUS: next_rdata = {12'h000, irq_status};
			IDX_IRQ_MASK: next_rdata = {12'h000, irq_mask};
			default: next_rdata = 16'h0000;
		endcase
		if (!mapped) begin
			next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready) begin
				prdata <= {16'h0000, next_rdata};
			end
		end
	end

	// parameters: written by software, reloaded by any restore
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			volt_thr <= DEF_VOLT_THR;
			temp_thr <= DEF_TEMP_THR;
			avg_interval <= DEF_AVG_INTERVAL;
		end else if (restore_any) begin
			volt_thr <= DEF_VOLT_THR;
			temp_thr <= DEF_TEMP_THR;
			avg_interval <= DEF_AVG_INTERVAL;
		end else if (wr_en && mapped) begin
			if (idx == IDX_VOLT_THR) begin
				volt_thr <= wval;
			end
			if (idx == IDX_TEMP_THR) begin
				temp_thr <= wval;
			end
			if (idx == IDX_AVG_INTERVAL) begin
				avg_interval <= wval;
			end
		end
	end

	// pending link settings; only the full restore touches them
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_addr <= DEF_BUS_ADDR;
			pend_baud <= DEF_BAUD;
		end else if (restore_full) begin
			pend_addr <= DEF_BUS_ADDR;
			pend_baud <= DEF_BAUD;
		end
	end

	// active link settings copy the pending ones once per reset, never in between
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link_loaded <= 1'b0;
			bus_addr_o <= DEF_BUS_ADDR;
			baud_o <= DEF_BAUD;
		end else if (!link_loaded) begin
			link_loaded <= 1'b1;
			bus_addr_o <= pend_addr;
			baud_o <= pend_baud;
		end
	end

	// limitation: pending values live in this bank and sys_rst_i reloads their defaults, so they do not survive a restart
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ref_run_o <= 1'b0;
			dev_restart_o <= 1'b0;
		end else begin
			ref_run_o <= cmd_wr && ((wval == CMD_FULL_REF) || (wval == CMD_KEEP_REF));
			dev_restart_o <= wr_en && mapped && (idx == IDX_RESTART) && (wval == CMD_RESTART);
		end
	end

	psc_save_engine #(
		.SAVE_CYC(SAVE_CYC)
	) u_save (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(save_go),
		.boot_mem_ok_i(boot_mem_ok_i),
		.nvm_done_i(nvm_done_i),
		.nvm_err_i(nvm_err_i),
		.nvm_req_o(nvm_req_o),
		.stat_o(save_st)
	);

	psc_supply_avg #(
		.STEP_CYC(STEP_CYC)
	) u_avg (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.supply_meas_i(supply_meas_i),
		.interval_i(avg_interval),
		.thr_i(volt_thr),
		.present_o(motor_power_o)
	);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			power_q <= 1'b0;
		end else begin
			power_q <= motor_power_o;
		end
	end

	assign irq_set = {power_q != motor_power_o, restore_any, save_st.done_err, save_st.done_ok};

	// sticky events; cleared at the edge that latches the read data, so no event slips between the two
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_status <= IRQ_ZERO;
			irq_mask <= IRQ_ZERO;
		end else begin
			if (access && !pready && !pwrite && mapped && (idx == IDX_IRQ_STATUS)) begin
				irq_status <= irq_set;
			end else begin
				irq_status <= irq_status | irq_set;
			end
			if (wr_en && mapped && (idx == IDX_IRQ_MASK)) begin
				irq_mask <= wval[3:0];
			end
		end
	end

	assign irq_o = |(irq_status & irq_mask);
	assign temp_thr_o = temp_thr;

	property p_thr_write;
		@(posedge clk_i) disable iff (sys_rst_i)
			(wr_en && mapped && idx == IDX_VOLT_THR && !restore_any) |=> (volt_thr == $past(wval));
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("voltage threshold not stored");

	property p_temp_default;
		@(posedge clk_i) disable iff (sys_rst_i) restore_any |=> (temp_thr == 16'h0046) && (volt_thr == 16'h00B9);
	endproperty
	a_temp_default: assert property (p_temp_default) else $error("restore missed thresholds");

	property p_full_ref;
		@(posedge clk_i) disable iff (sys_rst_i)
			(cmd_wr && wval == CMD_FULL_REF) |=> ref_run_o && (pend_addr == 8'h01) && (pend_baud == 16'h4B00);
	endproperty
	a_full_ref: assert property (p_full_ref) else $error("full restore incomplete");

	property p_keep_ref;
		@(posedge clk_i) disable iff (sys_rst_i)
			(cmd_wr && wval == CMD_KEEP_REF) |=> ref_run_o && (pend_addr == $past(pend_addr)) && $stable(pend_baud);
	endproperty
	a_keep_ref: assert property (p_keep_ref) else $error("keep restore changed link");

	property p_save_start;
		@(posedge clk_i) disable iff (sys_rst_i) save_go |=> ##1 nvm_req_o && save_st.busy;
	endproperty
	a_save_start: assert property (p_save_start) else $error("save did not start");

	property p_still_full;
		@(posedge clk_i) disable iff (sys_rst_i) (cmd_wr && wval == CMD_FULL_STILL) |=> !ref_run_o && (pend_addr == 8'h01);
	endproperty
	a_still_full: assert property (p_still_full) else $error("restore two moved or kept address");

	property p_still_keep;
		@(posedge clk_i) disable iff (sys_rst_i) (cmd_wr && wval == CMD_KEEP_STILL) |=> !ref_run_o && $stable(pend_addr);
	endproperty
	a_still_keep: assert property (p_still_keep) else $error("restore three moved or lost address");

	property p_link_hold;
		@(posedge clk_i) disable iff (sys_rst_i) link_loaded |=> $stable(bus_addr_o) && $stable(baud_o);
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link settings changed without reset");

	property p_restart;
		@(posedge clk_i) disable iff (sys_rst_i)
			(rd_done && mapped && idx == IDX_RESTART) |-> (prdata == 32'h0000_0000);
	endproperty
	a_restart: assert property (p_restart) else $error("restart register read nonzero");

	property p_rsvd;
		@(posedge clk_i) disable iff (sys_rst_i) (rd_done && rsvd) |-> (prdata == 32'h0000_0000);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero");

	property p_pready_pulse;
		@(posedge clk_i) disable iff (sys_rst_i) pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready held past one cycle");

	property p_pready_wait;
		@(posedge clk_i) disable iff (sys_rst_i) (access && !pready) |=> pready;
	endproperty
	a_pready_wait: assert property (p_pready_wait) else $error("ready missing after one wait state");

	property p_slverr_unmapped;
		@(posedge clk_i) disable iff (sys_rst_i) (access && !pready && !mapped) |=> pslverr && pready;
	endproperty
	a_slverr_unmapped: assert property (p_slverr_unmapped) else $error("unmapped access not refused");

	property p_slverr_pair;
		@(posedge clk_i) disable iff (sys_rst_i) pslverr |-> pready;
	endproperty
	a_slverr_pair: assert property (p_slverr_pair) else $error("error without ready");

	property p_rdata_high;
		@(posedge clk_i) disable iff (sys_rst_i) pready |-> (prdata[31:16] == 16'h0000);
	endproperty
	a_rdata_high: assert property (p_rdata_high) else $error("upper read half not zero");

	property p_restart_pulse;
		@(posedge clk_i) disable iff (sys_rst_i)
			(wr_en && mapped && idx == IDX_RESTART && wval == CMD_RESTART) |=> dev_restart_o;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart not requested");

	property p_restart_idle;
		@(posedge clk_i) disable iff (sys_rst_i)
			(wr_en && mapped && idx == IDX_RESTART && wval == 16'h0000) |=> !dev_restart_o;
	endproperty
	a_restart_idle: assert property (p_restart_idle) else $error("zero write restarted");

	property p_cmd_none;
		@(posedge clk_i) disable iff (sys_rst_i)
			(cmd_wr && wval == CMD_NONE) |=> !ref_run_o && !nvm_req_o && $stable(volt_thr) && $stable(temp_thr);
	endproperty
	a_cmd_none: assert property (p_cmd_none) else $error("zero command acted");

	property p_no_save;
		@(posedge clk_i) disable iff (sys_rst_i) (cmd_wr && wval != CMD_SAVE) |=> !nvm_req_o;
	endproperty
	a_no_save: assert property (p_no_save) else $error("save started by other command");

	property p_ref_cause;
		@(posedge clk_i) disable iff (sys_rst_i) ref_run_o |-> $past(cmd_wr);
	endproperty
	a_ref_cause: assert property (p_ref_cause) else $error("reference run without command");

	property p_rsvd_write;
		@(posedge clk_i) disable iff (sys_rst_i)
			(wr_en && rsvd) |=> $stable(volt_thr) && $stable(temp_thr) && $stable(avg_interval);
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed a parameter");

	property p_irq_sticky;
		@(posedge clk_i) disable iff (sys_rst_i)
			(irq_set != IRQ_ZERO) |=> ((irq_status & $past(irq_set)) == $past(irq_set));
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("event lost from status");

	property p_power_event;
		@(posedge clk_i) disable iff (sys_rst_i) (power_q != motor_power_o) |=> irq_status[IRQ_POWER];
	endproperty
	a_power_event: assert property (p_power_event) else $error("power change not flagged");

	property p_save_event;
		@(posedge clk_i) disable iff (sys_rst_i) save_st.done_err |=> irq_status[IRQ_SAVE_ERR];
	endproperty
	a_save_event: assert property (p_save_event) else $error("failed save not flagged");
endmodule : psc_regs
`default_nettype wire

// File: testbench/psc_nvm_model.sv
/*
 * behavioural non-volatile store behind the save engine: answers a save request promptly, slowly,
 * with an error, or never.
 * assumes nvm_req_i comes from a register clocked by clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module psc_nvm_model (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic nvm_req_i,
	input wire logic [1:0] mode_i,
	output logic nvm_done_o,
	output logic nvm_err_o
);
	logic [7:0] cnt;

	// mode 0 prompt, 1 slow, 2 failing, 3 silent; the slow answer stays well inside the save limit
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= 8'h00;
			nvm_done_o <= 1'b0;
			nvm_err_o <= 1'b0;
		end else begin
			nvm_done_o <= 1'b0;
			// error line means nothing outside done, so it toggles rather than holding a stale level
			nvm_err_o <= ~nvm_err_o;
			if (nvm_req_i && !nvm_done_o) begin
				cnt <= cnt + 8'h01;
				if (mode_i != 2'd3 && cnt == (mode_i == 2'd1 ? 8'd30 : 8'd4)) begin
					nvm_done_o <= 1'b1;
					nvm_err_o <= (mode_i == 2'd2);
					cnt <= 8'h00;
				end
			end else begin
				cnt <= 8'h00;
			end
		end
	end
endmodule : psc_nvm_model
`default_nettype wire

// File: testbench/tb_top.sv
/*
 * self-checking bench for the parameter store register bank, driven over apb.
 * assumes the design bodies keep the hand-over contract; short step and save counts.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import psc_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, boot_mem_ok_i = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [15:0] supply_meas_i = 0, temp_thr_o, baud_o, v, b, f;
	logic [1:0] mode = 0;
	logic [7:0] bus_addr_o;
	logic pready, pslverr, nvm_req_o, nvm_done_i, nvm_err_i, motor_power_o, ref_run_o, dev_restart_o, irq_o, e;
	logic [15:0] codes [4] = '{CMD_FULL_REF, CMD_KEEP_REF, CMD_FULL_STILL, CMD_KEEP_STILL};
	int n_mismatch = 0, samples_checked = 0, n_ref = 0, n_rst = 0, k;

	psc_regs #(.STEP_CYC(4), .SAVE_CYC(50)) i_psc_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .supply_meas_i(supply_meas_i), .boot_mem_ok_i(boot_mem_ok_i), .nvm_done_i(nvm_done_i),
		.nvm_err_i(nvm_err_i), .nvm_req_o(nvm_req_o), .motor_power_o(motor_power_o), .temp_thr_o(temp_thr_o),
		.bus_addr_o(bus_addr_o), .baud_o(baud_o), .ref_run_o(ref_run_o), .dev_restart_o(dev_restart_o), .irq_o(irq_o));
	psc_nvm_model i_psc_nvm_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .nvm_req_i(nvm_req_o), .mode_i(mode),
		.nvm_done_o(nvm_done_i), .nvm_err_o(nvm_err_i));

	initial begin
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		n_ref += (ref_run_o === 1'b1);
		n_rst += (dev_restart_o === 1'b1);
	end

	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ba

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task close_out;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	// entered right after a rising edge; one idle edge after release keeps psel from being set twice at once
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk_i);
		penable <= 1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_i);
	endtask : apb

	task do_reset;
		sys_rst_i <= 1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 0;
		@(posedge clk_i);
	endtask : do_reset

	task save_run(input logic [1:0] m);
		int n;
		n = 0;
		mode <= m;
		apb(1, ba(IDX_CMD), CMD_SAVE);
		apb(0, ba(IDX_CMD), 0);
		b = r[15:0];
		while (nvm_req_o !== 1'b0 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		repeat (2) @(posedge clk_i);
		apb(0, ba(IDX_CMD), 0);
		f = r[15:0];
		chk(|(b & BUSY_MASK), 1);
	endtask : save_run

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		close_out;
	end

	initial begin
		void'($urandom(32'h25A3));
		do_reset;
		chk({temp_thr_o, bus_addr_o, baud_o}, {DEF_TEMP_THR, DEF_BUS_ADDR, DEF_BAUD});
		apb(0, ba(IDX_VOLT_THR), 0); chk(r, {16'h0000, DEF_VOLT_THR});
		apb(0, ba(IDX_TEMP_THR), 0); chk(r, {16'h0000, DEF_TEMP_THR});
		apb(0, ba(IDX_CMD), 0); chk(r, 0);
		apb(0, ba(IDX_AVG_INTERVAL), 0); chk(r, {16'h0000, DEF_AVG_INTERVAL});
		for (int i = 0; i < 4; i++) begin
			k = (i < 2) ? IDX_RSVD_A_LO + $urandom_range(0, 9) : IDX_RSVD_B_LO + $urandom_range(0, 9);
			apb(1, ba(k[7:0]), 16'($urandom));
			apb(0, ba(k[7:0]), 0); chk({r, e}, 0);
		end
		apb(0, 12'h400, 0); chk({r, e}, 1);
		apb(1, 12'h1A2, 16'h0001); chk(e, 1);
		foreach (codes[i]) begin
			v = $urandom_range(180, 240);
			apb(1, ba(IDX_VOLT_THR), v);
			apb(1, ba(IDX_TEMP_THR), v);
			apb(0, ba(IDX_VOLT_THR), 0); chk(r, {16'h0000, v});
			k = n_ref;
			apb(1, ba(IDX_CMD), codes[i]);
			repeat (4) @(posedge clk_i);
			chk(n_ref - k, (i < 2));
			apb(0, ba(IDX_VOLT_THR), 0); chk(r, {16'h0000, DEF_VOLT_THR});
			chk(temp_thr_o, DEF_TEMP_THR);
			chk({bus_addr_o, baud_o}, {DEF_BUS_ADDR, DEF_BAUD});
		end
		v = $urandom_range(10, 69);
		apb(1, ba(IDX_TEMP_THR), v);
		apb(1, ba(IDX_CMD), CMD_NONE);
		apb(0, ba(IDX_TEMP_THR), 0); chk(r, {16'h0000, v});
		k = n_rst;
		apb(1, ba(IDX_RESTART), 16'h0000);
		repeat (3) @(posedge clk_i);
		chk(n_rst - k, 0);
		apb(1, ba(IDX_RESTART), CMD_RESTART);
		repeat (3) @(posedge clk_i);
		chk(n_rst - k, 1);
		apb(0, ba(IDX_RESTART), 0); chk(r, 0);
		do_reset;
		chk({bus_addr_o, baud_o}, {DEF_BUS_ADDR, DEF_BAUD});
		apb(0, ba(IDX_IRQ_STATUS), 0);
		apb(1, ba(IDX_IRQ_MASK), 16'h0001 << IRQ_SAVE_OK);
		save_run(0); chk(f, CODE_OK);
		chk(irq_o, 1);
		apb(0, ba(IDX_IRQ_STATUS), 0); chk(r[IRQ_SAVE_OK], 1);
		chk(irq_o, 0);
		save_run(1); chk(f, CODE_OK);
		apb(1, ba(IDX_IRQ_MASK), 0);
		save_run(2); chk({|(f & BUSY_MASK), |(f & ERR_MASK)}, 2'b01);
		chk(irq_o, 0);
		save_run(3); chk({|(f & BUSY_MASK), |(f & ERR_MASK)}, 2'b01);
		apb(0, ba(IDX_IRQ_STATUS), 0); chk(r[IRQ_SAVE_ERR], 1);
		v = $urandom_range(180, 240);
		apb(1, ba(IDX_VOLT_THR), v);
		apb(1, ba(IDX_AVG_INTERVAL), 16'h0002);
		supply_meas_i <= v;
		repeat (40) @(posedge clk_i);
		chk(motor_power_o, 1);
		supply_meas_i <= v - 16'h0001;
		repeat (40) @(posedge clk_i);
		chk(motor_power_o, 0);
		boot_mem_ok_i <= 0;
		do_reset;
		apb(0, ba(IDX_CMD), 0); chk(r[15:0] != 0, 1);
		close_out;
	end
endmodule : tb_top
`default_nettype wire
